// *** mtr_pkg.sv ***
// Constants, types and field layouts shared by the memory-type resolver.
// Behaviour
// - Memory types are computed only for requests from coherency-domain devices.
// - Legacy mode uses write-back for all structures and the final page.
// - Scalable mode uses write-back for every translation structure access.
// - Scalable final page with cache disable set is uncacheable.
// - Second-stage only, extended types disabled: final page is write-back.
// - Second-stage only, extended types enabled: final page takes leaf type.
// - First-stage and nested derive attribute type, then range-register type.
// - First-stage only combines attribute and range types through the table.
// - Nested without extended types combines attribute and range types.
// - Nested with extended types uses leaf ignore bit and leaf type.
// - Leaf ignore bit set: leaf type replaces the attribute type.
// - Leaf ignore bit clear: combine attribute type with leaf type as range.
// - Pass-through final page is write-back regardless of extended enable.
// - Typing bits may come from cached entries; software must invalidate.
// - Combine table rows for uncacheable and write-combining range types.
// - Combine table rows for write-through, write-back, write-protect ranges.
// - Attribute index is four attribute plus two cache-disable plus through.
// - Range type: disabled gives uncacheable, else fixed, variable, default.
package mtr_pkg;

    // Memory type encodings.
    localparam logic [2:0] MTR_UC  = 3'h0;
    localparam logic [2:0] MTR_WC  = 3'h1;
    localparam logic [2:0] MTR_WT  = 3'h4;
    localparam logic [2:0] MTR_WP  = 3'h5;
    localparam logic [2:0] MTR_WB  = 3'h6;
    localparam logic [2:0] MTR_UCM = 3'h7;

    // Translation table modes and translation types.
    localparam logic [1:0] MTR_TTM_LEGACY   = 2'h0;
    localparam logic [1:0] MTR_TTM_SCALABLE = 2'h1;
    localparam logic [2:0] MTR_PASID_TRANSLATION_TYPE_FS      = 3'h1;
    localparam logic [2:0] MTR_PASID_TRANSLATION_TYPE_SS      = 3'h2;
    localparam logic [2:0] MTR_PASID_TRANSLATION_TYPE_NEST    = 3'h3;
    localparam logic [2:0] MTR_PASID_TRANSLATION_TYPE_PT      = 3'h4;

    // Register byte offsets.
    localparam logic [7:0] MTR_OFS_CTRL     = 8'h00;
    localparam logic [7:0] MTR_OFS_FIXED    = 8'h04;
    localparam logic [7:0] MTR_OFS_STATUS   = 8'h08;
    localparam logic [7:0] MTR_OFS_VAR      = 8'h10;
    localparam logic [7:0] MTR_VAR_STRIDE   = 8'h08;
    localparam logic [7:0] MTR_VAR_MASK_OFS = 8'h04;

    // Field positions.
    localparam int MTR_CTRL_EN_BIT   = 0;
    localparam int MTR_CTRL_FIX_BIT  = 1;
    localparam int MTR_CTRL_DEF_LSB  = 4;
    localparam int MTR_VAR_VALID_BIT = 11;
    localparam int MTR_VAR_ADDR_LSB  = 12;
    localparam int MTR_LOW_MB_LSB    = 20;
    localparam int MTR_STAT_APP_BIT  = 4;
    localparam int MTR_STAT_FLAG_BIT = 5;
    localparam int MTR_STAT_CNT_LSB  = 8;

    // Reset values.
    localparam logic [31:0] MTR_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] MTR_FIXED_RST = 32'h0000_0000;
    localparam logic [31:0] MTR_VAR_RST   = 32'h0000_0000;

    // Kind of access that the walker is typing.
    typedef enum logic [2:0] {
        MTR_ACC_ROOT,
        MTR_ACC_CONTEXT,
        MTR_ACC_PASID_DIR,
        MTR_ACC_PASID_TBL,
        MTR_ACC_FS_STRUCT,
        MTR_ACC_SS_STRUCT,
        MTR_ACC_FINAL
    } mtr_access_t;

    // Request from the translation walker.
    typedef struct packed {
        logic        coherent;
        mtr_access_t kind;
        logic [1:0]  translation_table_mode;
        logic        cache_disable_bit;
        logic [2:0]  pasid_translation_type;
        logic        extended_type_enable;
        logic        attribute_bit;
        logic        page_cache_disable_bit;
        logic        page_write_through_bit;
        logic        ignore_attribute_bit;
        logic [2:0]  extended_type_field;
        logic [23:0] page_attribute_table;
        logic [31:0] phys_addr;
    } mtr_req_t;

    // Answer to the coherent fabric.
    typedef struct packed {
        logic       applies;
        logic       flag;
        logic [2:0] mem_type;
    } mtr_resp_t;

endpackage

// *** mtr_eff_type.sv ***
// Effective memory type from a range-position type and an attribute type.
`timescale 1ns/1ps
`default_nettype none
module mtr_eff_type (
    // Types to combine.
    input  wire logic [2:0] range_type,
    input  wire logic [2:0] attr_type,
    // Combined type.
    output var  logic [2:0] eff_type
);

    // Table lookup; reserved range encodings fall back to uncacheable.
    always_comb
    begin
        eff_type = mtr_pkg::MTR_UC;
        case (range_type)
            mtr_pkg::MTR_UC:
                eff_type = (attr_type == mtr_pkg::MTR_WC) ? mtr_pkg::MTR_WC
                                                          : mtr_pkg::MTR_UC;
            mtr_pkg::MTR_WC:
                eff_type = (attr_type == mtr_pkg::MTR_UC ||
                            attr_type == mtr_pkg::MTR_WT ||
                            attr_type == mtr_pkg::MTR_WP) ? mtr_pkg::MTR_UC
                                                          : mtr_pkg::MTR_WC;
            mtr_pkg::MTR_WT:
                if (attr_type == mtr_pkg::MTR_UC || attr_type == mtr_pkg::MTR_UCM)
                    eff_type = mtr_pkg::MTR_UC;
                else if (attr_type == mtr_pkg::MTR_WB)
                    eff_type = mtr_pkg::MTR_WT;
                else
                    eff_type = attr_type;
            mtr_pkg::MTR_WB:
                eff_type = (attr_type == mtr_pkg::MTR_UCM) ? mtr_pkg::MTR_UC
                                                           : attr_type;
            mtr_pkg::MTR_WP:
                if (attr_type == mtr_pkg::MTR_UCM)
                    eff_type = mtr_pkg::MTR_WC;
                else if (attr_type == mtr_pkg::MTR_WB)
                    eff_type = mtr_pkg::MTR_WP;
                else
                    eff_type = attr_type;
            default:
                eff_type = mtr_pkg::MTR_UC;
        endcase
    end

endmodule
`default_nettype wire

// *** mtr_range_sel.sv ***
// Range-register memory type for one physical address.
`timescale 1ns/1ps
`default_nettype none
module mtr_range_sel #(
    parameter int NUM_VAR = 2
) (
    // Address and range configuration.
    input  wire logic [31:0]              phys_addr,
    input  wire logic [31:0]              ctrl,
    input  wire logic [31:0]              fixed_cfg,
    input  wire logic [NUM_VAR-1:0][31:0] var_base,
    input  wire logic [NUM_VAR-1:0][31:0] var_mask,
    // Resulting range type.
    output var  logic [2:0]               range_type
);

    localparam int AL = mtr_pkg::MTR_VAR_ADDR_LSB;

    // Variable matches merge by precedence; undefined overlaps keep the first.
    always_comb
    begin
        logic       found;
        logic [2:0] t;
        logic [2:0] v;
        found = 1'b0;
        t = ctrl[mtr_pkg::MTR_CTRL_DEF_LSB +: 3];
        v = mtr_pkg::MTR_UC;
        for (int i = 0; i < NUM_VAR; i++)
        begin
            v = var_base[i][2:0];
            if (var_mask[i][mtr_pkg::MTR_VAR_VALID_BIT] &&
                ((phys_addr[31:AL] & var_mask[i][31:AL]) ==
                 (var_base[i][31:AL] & var_mask[i][31:AL])))
            begin
                if (!found)
                    t = v;
                else if (t == mtr_pkg::MTR_UC || v == mtr_pkg::MTR_UC)
                    t = mtr_pkg::MTR_UC;
                else if ((t == mtr_pkg::MTR_WT && v == mtr_pkg::MTR_WB) ||
                         (t == mtr_pkg::MTR_WB && v == mtr_pkg::MTR_WT))
                    t = mtr_pkg::MTR_WT;
                found = 1'b1;
            end
        end
        if (ctrl[mtr_pkg::MTR_CTRL_FIX_BIT] &&
            phys_addr[31:mtr_pkg::MTR_LOW_MB_LSB] == '0)
            t = fixed_cfg[2:0];
        if (!ctrl[mtr_pkg::MTR_CTRL_EN_BIT])
            t = mtr_pkg::MTR_UC;
        range_type = t;
    end

endmodule
`default_nettype wire

// *** mtr_resolver.sv ***
// Memory-type resolver top with its Wishbone range-register file.
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mtr_resolver #(
    parameter int NUM_VAR = 2
) (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Walker request.
    input  wire logic               req_valid,
    input  wire mtr_pkg::mtr_req_t  req,
    // Fabric answer.
    output var  logic               resp_valid,
    output var  mtr_pkg::mtr_resp_t resp,
    // Wishbone slave.
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output var  logic [31:0]        wb_dat_o,
    output var  logic               wb_ack_o
);

    logic [31:0]              ctrl_q;
    logic [31:0]              fixed_q;
    logic [NUM_VAR-1:0][31:0] var_base_q;
    logic [NUM_VAR-1:0][31:0] var_mask_q;
    logic [31:0]              rdata_d;
    logic [31:0]              rdata_q;
    logic                     ack_q;
    logic                     wr_go;
    logic                     rd_go;
    logic [7:0]               flag_cnt_q;
    logic                     resp_valid_q;
    mtr_pkg::mtr_resp_t       resp_q;
    mtr_pkg::mtr_resp_t       resp_d;
    logic [2:0]               attr_idx;
    logic [2:0]               attr_type;
    logic [2:0]               range_type;
    logic [2:0]               combine_m;
    logic [2:0]               eff_type;
    logic                     nest_ext;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        return r;
    endfunction

    // Byte offset of the base or mask word of variable range i.
    function automatic logic [7:0] var_ofs(input int i, input logic mask);
        logic [7:0] o;
        o = mtr_pkg::MTR_OFS_VAR + 8'(i) * mtr_pkg::MTR_VAR_STRIDE;
        if (mask)
            o = o + mtr_pkg::MTR_VAR_MASK_OFS;
        return o;
    endfunction

    // A request is taken once, in the cycle before ack rises.
    assign wr_go = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
    assign rd_go = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;

    // Acknowledge one cycle after the strobe, drop it the cycle after.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end

    // Control and fixed-range registers.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl_q  <= mtr_pkg::MTR_CTRL_RST;
            fixed_q <= mtr_pkg::MTR_FIXED_RST;
        end
        else if (wr_go)
        begin
            if (wb_adr_i == mtr_pkg::MTR_OFS_CTRL)
                ctrl_q <= merge_sel(ctrl_q, wb_dat_i, wb_sel_i);
            if (wb_adr_i == mtr_pkg::MTR_OFS_FIXED)
                fixed_q <= merge_sel(fixed_q, wb_dat_i, wb_sel_i);
        end
    end

    // Variable-range base and mask registers.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_VAR; i++)
            begin
                var_base_q[i] <= mtr_pkg::MTR_VAR_RST;
                var_mask_q[i] <= mtr_pkg::MTR_VAR_RST;
            end
        end
        else if (wr_go)
        begin
            for (int i = 0; i < NUM_VAR; i++)
            begin
                if (wb_adr_i == var_ofs(i, 1'b0))
                    var_base_q[i] <= merge_sel(var_base_q[i], wb_dat_i,
                                               wb_sel_i);
                if (wb_adr_i == var_ofs(i, 1'b1))
                    var_mask_q[i] <= merge_sel(var_mask_q[i], wb_dat_i,
                                               wb_sel_i);
            end
        end
    end

    // Read mux; unmapped offsets read as zero and are still acknowledged.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (wb_adr_i == mtr_pkg::MTR_OFS_CTRL)
            rdata_d = ctrl_q;
        if (wb_adr_i == mtr_pkg::MTR_OFS_FIXED)
            rdata_d = fixed_q;
        if (wb_adr_i == mtr_pkg::MTR_OFS_STATUS)
        begin
            rdata_d[2:0] = resp_q.mem_type;
            rdata_d[mtr_pkg::MTR_STAT_APP_BIT] = resp_q.applies;
            rdata_d[mtr_pkg::MTR_STAT_FLAG_BIT] = resp_q.flag;
            rdata_d[mtr_pkg::MTR_STAT_CNT_LSB +: 8] = flag_cnt_q;
        end
        for (int i = 0; i < NUM_VAR; i++)
        begin
            if (wb_adr_i == var_ofs(i, 1'b0))
                rdata_d = var_base_q[i];
            if (wb_adr_i == var_ofs(i, 1'b1))
                rdata_d = var_mask_q[i];
        end
    end

    // Read data is captured with the acknowledge.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            rdata_q <= 32'h0000_0000;
        else if (rd_go)
            rdata_q <= rdata_d;
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Attribute type selected from the table carried with the request.
    assign attr_idx = {req.attribute_bit, req.page_cache_disable_bit,
                       req.page_write_through_bit};
    assign attr_type = req.page_attribute_table[3*attr_idx +: 3];

    // Range type for the target address.
    mtr_range_sel #(
        .NUM_VAR    (NUM_VAR)
    ) u_range (
        .phys_addr  (req.phys_addr),
        .ctrl       (ctrl_q),
        .fixed_cfg  (fixed_q),
        .var_base   (var_base_q),
        .var_mask   (var_mask_q),
        .range_type (range_type)
    );

    // Nested with extended types puts the leaf type in the range position.
    assign nest_ext = req.pasid_translation_type == mtr_pkg::MTR_PASID_TRANSLATION_TYPE_NEST &&
                      req.extended_type_enable;
    assign combine_m = nest_ext ? req.extended_type_field : range_type;

    mtr_eff_type u_eff (
        .range_type (combine_m),
        .attr_type  (attr_type),
        .eff_type   (eff_type)
    );

    // Type selection from mode, access kind and entry fields.
    always_comb
    begin
        resp_d = '0;
        resp_d.applies = 1'b1;
        if (!req.coherent)
            resp_d.applies = 1'b0;
        else if (req.translation_table_mode == mtr_pkg::MTR_TTM_LEGACY)
            resp_d.mem_type = mtr_pkg::MTR_WB;
        else if (req.translation_table_mode != mtr_pkg::MTR_TTM_SCALABLE)
        begin
            resp_d.applies = 1'b0;
            resp_d.flag = 1'b1;
        end
        else if (req.kind != mtr_pkg::MTR_ACC_FINAL)
            resp_d.mem_type = mtr_pkg::MTR_WB;
        else if (req.cache_disable_bit)
            resp_d.mem_type = mtr_pkg::MTR_UC;
        else
        begin
            case (req.pasid_translation_type)
                mtr_pkg::MTR_PASID_TRANSLATION_TYPE_FS:
                    resp_d.mem_type = eff_type;
                mtr_pkg::MTR_PASID_TRANSLATION_TYPE_SS:
                    resp_d.mem_type = req.extended_type_enable
                                    ? req.extended_type_field
                                    : mtr_pkg::MTR_WB;
                mtr_pkg::MTR_PASID_TRANSLATION_TYPE_NEST:
                    if (req.extended_type_enable && req.ignore_attribute_bit)
                        resp_d.mem_type = req.extended_type_field;
                    else
                        resp_d.mem_type = eff_type;
                mtr_pkg::MTR_PASID_TRANSLATION_TYPE_PT:
                    resp_d.mem_type = mtr_pkg::MTR_WB;
                default:
                begin
                    resp_d.applies = 1'b0;
                    resp_d.flag = 1'b1;
                end
            endcase
        end
    end

    // Answer registered one cycle after each request, from fields as given.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            resp_valid_q <= 1'b0;
            resp_q <= '0;
        end
        else
        begin
            resp_valid_q <= req_valid;
            if (req_valid)
                resp_q <= resp_d;
        end
    end

    // Count of flagged requests, wrapping.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            flag_cnt_q <= 8'h00;
        else if (req_valid && resp_d.flag)
            flag_cnt_q <= flag_cnt_q + 8'h01;
    end

    assign resp_valid = resp_valid_q;
    assign resp = resp_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_final;
        req_valid && req.coherent && !req.cache_disable_bit &&
        req.translation_table_mode == mtr_pkg::MTR_TTM_SCALABLE &&
        req.kind == mtr_pkg::MTR_ACC_FINAL;
    endsequence

    sequence s_answer(logic [2:0] t);
        resp_valid && resp.applies && !resp.flag && resp.mem_type == t;
    endsequence

    noncoh_skip_a: assert property (req_valid && !req.coherent |=>
        resp_valid && !resp.applies && !resp.flag)
        else $error("non-coherent request was typed");
    legacy_wb_a: assert property (req_valid && req.coherent &&
        req.translation_table_mode == mtr_pkg::MTR_TTM_LEGACY |=>
        s_answer(mtr_pkg::MTR_WB))
        else $error("legacy access not write-back");
    struct_wb_a: assert property (req_valid && req.coherent &&
        req.translation_table_mode == mtr_pkg::MTR_TTM_SCALABLE &&
        req.kind != mtr_pkg::MTR_ACC_FINAL |=> s_answer(mtr_pkg::MTR_WB))
        else $error("scalable structure access not write-back");
    cd_uc_a: assert property (req_valid && req.coherent &&
        req.cache_disable_bit && req.kind == mtr_pkg::MTR_ACC_FINAL &&
        req.translation_table_mode == mtr_pkg::MTR_TTM_SCALABLE |=>
        s_answer(mtr_pkg::MTR_UC))
        else $error("cache disable did not force uncacheable");
    ss_wb_a: assert property (s_final ##0
        req.pasid_translation_type == mtr_pkg::MTR_PASID_TRANSLATION_TYPE_SS &&
        !req.extended_type_enable |=> s_answer(mtr_pkg::MTR_WB))
        else $error("second-stage page not write-back");
    ss_emt_a: assert property (s_final ##0
        req.pasid_translation_type == mtr_pkg::MTR_PASID_TRANSLATION_TYPE_SS &&
        req.extended_type_enable |=>
        resp.mem_type == $past(req.extended_type_field))
        else $error("second-stage page ignored leaf type");
    nest_ignore_attribute_bit_a: assert property (s_final ##0 nest_ext &&
        req.ignore_attribute_bit |=>
        resp.mem_type == $past(req.extended_type_field))
        else $error("ignore bit did not select leaf type");
    nest_combine_a: assert property (s_final ##0 nest_ext &&
        !req.ignore_attribute_bit && req.extended_type_field ==
        mtr_pkg::MTR_WB |=> resp.mem_type == $past(attr_type) ||
        ($past(attr_type) == mtr_pkg::MTR_UCM &&
         resp.mem_type == mtr_pkg::MTR_UC))
        else $error("nested leaf combine wrong");
    pt_wb_a: assert property (s_final ##0
        req.pasid_translation_type == mtr_pkg::MTR_PASID_TRANSLATION_TYPE_PT |=>
        s_answer(mtr_pkg::MTR_WB))
        else $error("pass-through page not write-back");
    range_off_a: assert property (!ctrl_q[mtr_pkg::MTR_CTRL_EN_BIT] |->
        range_type == mtr_pkg::MTR_UC)
        else $error("disabled ranges not uncacheable");
    bad_mode_a: assert property (req_valid && req.coherent &&
        req.translation_table_mode > mtr_pkg::MTR_TTM_SCALABLE |=>
        resp_valid && resp.flag && !resp.applies)
        else $error("reserved mode not flagged");
    wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !ack_q |=>
        wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge timing wrong");

endmodule
`default_nettype wire

// *** mtr_walker_model.sv ***
// Walker and fabric model that issues typing requests and takes answers.
`timescale 1ns/1ps
`default_nettype none
module mtr_walker_model (
    // Clock.
    input  wire logic               clk,
    // Request side.
    output var  logic               req_valid,
    output var  mtr_pkg::mtr_req_t  req,
    // Answer side.
    input  wire logic               resp_valid,
    input  wire mtr_pkg::mtr_resp_t resp
);
    // The port stays quiet until the first request.
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end
    // Sends two requests back to back and takes the answer to each.
    task automatic issue2(input mtr_pkg::mtr_req_t a, b,
                          output mtr_pkg::mtr_resp_t ra, rb,
                          output logic va, vb);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= a;
        @(posedge clk);
        req <= b;
        @(negedge clk);
        va = resp_valid;
        ra = resp;
        @(posedge clk);
        req_valid <= 1'b0;
        req <= ~b;
        @(negedge clk);
        vb = resp_valid;
        rb = resp;
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the memory-type resolver.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        mtr_pkg::mtr_req_t  r;
        mtr_pkg::mtr_resp_t e;
    } mtr_row_t;
    localparam logic [23:0] pat_tbl = {mtr_pkg::MTR_UC, mtr_pkg::MTR_WB,
        mtr_pkg::MTR_WP, mtr_pkg::MTR_WC, mtr_pkg::MTR_UC,
        mtr_pkg::MTR_UCM, mtr_pkg::MTR_WT, mtr_pkg::MTR_WB};
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               req_valid, resp_valid, wb_ack_o;
    mtr_pkg::mtr_req_t  req;
    mtr_pkg::mtr_resp_t resp;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]         wb_adr_i = 8'h00;
    logic [3:0]         wb_sel_i = 4'h0;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o;
    int                 miscompares = 0, checks_done = 0;
    mtr_row_t           rows[$];

    mtr_resolver dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req(req), .resp_valid(resp_valid), .resp(resp),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    mtr_walker_model walker (.clk(clk), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp(resp));

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Compares one value against its expectation.
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_dat_i} <= {3'b000, ~d};
        if (n >= 20)
        begin
            miscompares++;
            final_report();
        end
    endtask

    // Builds one row: request fields beside the answer they should give.
    function automatic void add(logic c, logic [1:0] m, logic [2:0] k,
        logic cd, logic [2:0] tt, logic em, logic [2:0] ix, logic ip,
        logic [2:0] et, logic [1:0] s, logic f, logic [2:0] t);
        mtr_row_t w;
        w = '0;
        w.r.coherent = c;
        w.r.kind = mtr_pkg::mtr_access_t'(k);
        w.r.translation_table_mode = m;
        w.r.cache_disable_bit = cd;
        w.r.pasid_translation_type = tt;
        w.r.extended_type_enable = em;
        {w.r.attribute_bit, w.r.page_cache_disable_bit,
         w.r.page_write_through_bit} = ix;
        w.r.ignore_attribute_bit = ip;
        w.r.extended_type_field = et;
        w.r.page_attribute_table = pat_tbl;
        w.r.phys_addr = (s == 2'h1) ? 32'h0000_1000 :
                        (s == 2'h2) ? 32'h1000_0000 : 32'h8000_0000;
        w.e = {c & ~f, f, t};
        rows.push_back(w);
    endfunction

    // Sends rows in back-to-back pairs and checks every answer.
    task automatic run(input int lo, input int hi);
        mtr_pkg::mtr_resp_t ra, rb;
        logic               va, vb;
        for (int i = lo; i < hi; i += 2)
        begin
            walker.issue2(rows[i].r, rows[i+1].r, ra, rb, va, vb);
            chk({va, 26'h0, ra}, {1'b1, 26'h0, rows[i].e});
            chk({vb, 26'h0, rb}, {1'b1, 26'h0, rows[i+1].e});
        end
    endtask

    // Cuts a hang short.
    initial
    begin
        #400000;
        miscompares++;
        final_report();
    end

    // Main sequence: reset, table of rows, then the awkward cases.
    initial
    begin
        logic [31:0] q, s;
        add(1,1,6,0,1,0,4,0,0,0,0,mtr_pkg::MTR_WC);
        add(1,1,6,0,1,0,0,0,0,0,0,mtr_pkg::MTR_UC);
        add(0,1,6,0,1,0,0,0,0,0,0,mtr_pkg::MTR_UC);
        add(1,0,0,0,0,0,0,0,0,0,0,mtr_pkg::MTR_WB);
        add(1,0,6,1,0,0,0,0,0,0,0,mtr_pkg::MTR_WB);
        add(1,1,3,0,0,0,0,0,0,0,0,mtr_pkg::MTR_WB);
        add(1,1,5,1,0,0,0,0,0,0,0,mtr_pkg::MTR_WB);
        add(1,1,6,1,2,1,0,0,5,0,0,mtr_pkg::MTR_UC);
        add(1,1,6,0,2,0,0,0,5,0,0,mtr_pkg::MTR_WB);
        add(1,1,6,0,2,1,0,0,5,0,0,mtr_pkg::MTR_WP);
        add(1,1,6,0,1,0,4,0,0,0,0,mtr_pkg::MTR_WC);
        add(1,1,6,0,1,0,2,0,0,0,0,mtr_pkg::MTR_UC);
        add(1,1,6,0,1,0,0,0,0,1,0,mtr_pkg::MTR_WC);
        add(1,1,6,0,1,0,2,0,0,2,0,mtr_pkg::MTR_WC);
        add(1,1,6,0,1,0,3,0,0,0,0,mtr_pkg::MTR_UC);
        add(1,1,6,0,1,0,1,0,0,2,0,mtr_pkg::MTR_WT);
        add(1,1,6,0,3,0,5,0,0,0,0,mtr_pkg::MTR_WP);
        add(1,1,6,0,3,1,0,1,0,0,0,mtr_pkg::MTR_UC);
        add(1,1,6,0,3,1,0,0,5,0,0,mtr_pkg::MTR_WP);
        add(1,1,6,0,3,1,2,0,6,0,0,mtr_pkg::MTR_UC);
        add(1,1,6,0,3,1,4,0,6,0,0,mtr_pkg::MTR_WC);
        add(1,1,6,0,4,1,0,0,5,0,0,mtr_pkg::MTR_WB);
        add(1,1,6,0,0,0,0,0,0,0,1,mtr_pkg::MTR_UC);
        add(1,3,6,0,1,0,0,0,0,0,1,mtr_pkg::MTR_UC);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({resp_valid, wb_ack_o, 25'h0, resp}, 32'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        wb(1'b0, mtr_pkg::MTR_OFS_CTRL, 32'h0, q);
        chk(q, mtr_pkg::MTR_CTRL_RST);
        wb(1'b0, mtr_pkg::MTR_OFS_FIXED, 32'h0, q);
        chk(q, mtr_pkg::MTR_FIXED_RST);
        wb(1'b0, mtr_pkg::MTR_OFS_VAR + mtr_pkg::MTR_VAR_MASK_OFS, 32'h0, q);
        chk(q, mtr_pkg::MTR_VAR_RST);
        run(0, 2);
        $display("test reset done");
        // Enabled ranges, fixed WC, default WT, variable WP at 256 MB.
        wb(1'b1, mtr_pkg::MTR_OFS_CTRL, 32'h0000_0043, q);
        wb(1'b1, mtr_pkg::MTR_OFS_FIXED, 32'h0000_0001, q);
        wb(1'b1, mtr_pkg::MTR_OFS_VAR, 32'h1000_0005, q);
        wb(1'b1, 8'h14, 32'hF000_0800, q);
        wb(1'b0, mtr_pkg::MTR_OFS_CTRL, 32'h0, q);
        chk(q, 32'h0000_0043);
        run(2, rows.size());
        @(negedge clk);
        chk({31'h0, resp_valid}, 32'h0);
        $display("test table done");
        wb(1'b0, mtr_pkg::MTR_OFS_STATUS, 32'h0, s);
        chk(s[15:0], 16'h0220);
        wb(1'b1, mtr_pkg::MTR_OFS_STATUS, 32'hFFFF_FFFF, q);
        wb(1'b0, mtr_pkg::MTR_OFS_STATUS, 32'h0, q);
        chk(q, s);
        wb(1'b1, 8'h40, 32'hA5A5_A5A5, q);
        wb(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
        $display("test registers done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({resp_valid, 26'h0, resp}, 32'h0);
        wb(1'b0, mtr_pkg::MTR_OFS_CTRL, 32'h0, q);
        chk(q, mtr_pkg::MTR_CTRL_RST);
        run(0, 2);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
